// ===== logic/pca_pkg.sv
// Purpose: Shared constants and types of the counter array
// Assumes: Register byte address is four times the register index
// Notes:   Bus data is 32 bits, registers use the low byte only
package pca_pkg;
    // ----------------------------------------------------------------
    // Sizes and register indexes
    // ----------------------------------------------------------------
    localparam int         NUM_MODULES      = 5;
    localparam int         ADDR_W           = 12;
    localparam logic [7:0] IDX_CLOCK_SPEED  = 8'h8f;
    localparam logic [7:0] IDX_ARRAY_CTRL   = 8'hd8;
    localparam logic [7:0] IDX_ARRAY_MODE   = 8'hd9;
    localparam logic [7:0] IDX_MODULE_MODE  = 8'hda;
    localparam logic [7:0] IDX_COUNTER_LOW  = 8'he9;
    localparam logic [7:0] IDX_COMPARE_LOW  = 8'hea;
    localparam logic [7:0] IDX_COUNTER_HIGH = 8'hf9;
    localparam logic [7:0] IDX_COMPARE_HIGH = 8'hfa;
    localparam logic [7:0] RESET_BYTE       = 8'h00;
    localparam logic [1:0] RESP_OKAY        = 2'b00;
    localparam logic [1:0] RESP_SLVERR      = 2'b10;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_OVERFLOW = 7;
    localparam int CTRL_RUN      = 6;
    localparam int MODE_WDOG     = 6;
    localparam int MODE_SRC_HI   = 2;
    localparam int MODE_SRC_LO   = 1;
    localparam int MODE_OVF_IE   = 0;
    localparam int SPEED_X2      = 0;
    localparam int EXT_PIN       = 2;
    localparam int FIRST_MOD_PIN = 3;
    // ----------------------------------------------------------------
    // Timing: oscillator periods per count event
    // ----------------------------------------------------------------
    localparam logic [3:0] PER_MC_STD   = 4'd12;
    localparam logic [3:0] PER_MC_X2    = 4'd6;
    localparam logic [3:0] PER_FAST_STD = 4'd4;
    localparam logic [3:0] PER_FAST_X2  = 4'd2;

    typedef enum logic [1:0] {
        SRC_MACHINE = 2'b00,
        SRC_FAST    = 2'b01,
        SRC_TIMER0  = 2'b10,
        SRC_EXT     = 2'b11
    } count_source_t;

    typedef struct packed {
        logic reserved;
        logic comparator_enable;
        logic capture_rising_enable;
        logic capture_falling_enable;
        logic flag_on_match;
        logic toggle_on_match;
        logic pwm_enable;
        logic module_irq_enable;
    } module_mode_t;

    function automatic logic in_group(input logic [7:0] idx, input logic [7:0] base);
        return (idx >= base) && (idx < base + 8'(NUM_MODULES));
    endfunction

    function automatic logic [3:0] period(input logic x2, input logic fast);
        if (fast) begin
            return x2 ? PER_FAST_X2 : PER_FAST_STD;
        end
        return x2 ? PER_MC_X2 : PER_MC_STD;
    endfunction
endpackage

// ===== logic/compare_module.sv
// Purpose: One capture/compare module fed by the shared counter
// Assumes: Pin edges arrive already synchronised, one pulse per edge
// Notes:   Capture loads the compare pair, which doubles as capture pair
`timescale 1ns/1ps
module compare_module (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire pca_pkg::module_mode_t mode,
    input  wire logic [15:0]           count_now,
    input  wire logic [15:0]           count_next,
    input  wire logic                  count_tick,
    input  wire logic                  low_we,
    input  wire logic                  high_we,
    input  wire logic [7:0]            wdata,
    input  wire logic                  pin_rise,
    input  wire logic                  pin_fall,
    output logic [7:0]                 compare_low,
    output logic [7:0]                 compare_high,
    output logic                       match,
    output logic                       event_pulse,
    output logic                       pin_level,
    output logic                       pin_owned
);
    logic pwm_on;
    logic capture;
    logic reload;

    assign pwm_on      = mode.pwm_enable && mode.comparator_enable;
    assign match       = count_tick && mode.comparator_enable && !pwm_on
                         && (count_next == {compare_high, compare_low});
    assign capture     = (pin_rise && mode.capture_rising_enable)
                         || (pin_fall && mode.capture_falling_enable);
    assign reload      = count_tick && pwm_on && (count_now[7:0] == 8'hff);
    assign event_pulse = capture || (match && mode.flag_on_match);
    assign pin_owned   = pwm_on || mode.toggle_on_match;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_low  <= pca_pkg::RESET_BYTE;
            compare_high <= pca_pkg::RESET_BYTE;
        end else if (capture) begin
            compare_low  <= count_now[7:0];
            compare_high <= count_now[15:8];
        end else begin
            if (low_we) begin
                compare_low <= wdata;
            end else if (reload) begin
                compare_low <= compare_high;
            end
            if (high_we) begin
                compare_high <= wdata;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_level <= 1'b1;
        end else if (pwm_on) begin
            pin_level <= (count_now[7:0] >= compare_low);
        end else if (match && mode.toggle_on_match) begin
            pin_level <= !pin_level;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence capture_seen;
        capture && !low_we && !high_we;
    endsequence

    chk_capture_copy: assert property (
        capture_seen |=> {compare_high, compare_low} == $past(count_now))
        else $error("capture did not copy counter");
    chk_pwm_level: assert property (
        pwm_on && $stable(pwm_on) |-> pin_level == ($past(count_now[7:0]) >= $past(compare_low)))
        else $error("pwm level wrong");
    chk_pwm_reload: assert property (
        reload && !capture && !low_we |=> compare_low == $past(compare_high))
        else $error("pwm reload missed");
    chk_toggle_match: assert property (
        match && mode.toggle_on_match |=> pin_level != $past(pin_level))
        else $error("pin did not toggle");
    chk_no_match_off: assert property (
        !mode.comparator_enable |-> !match)
        else $error("match with comparator off");
endmodule

// ===== logic/counter_array_capture_compare.sv
// Purpose: Shared 16-bit counter with five capture/compare modules
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   Port 1 bits not owned by the array follow the port latch
//
// Behaviour
// - Counter counts machine cycles, fast clock, timer 0 overflow or external input.
// - Machine cycle is 12 oscillator clocks, or 6 in double speed.
// - One shared 16-bit counter is the time base of all modules.
// - Module flags and counter overflow combine into one request.
// - External count on port bit 2, modules on bits 3 to 7.
// - Each module captures, times, toggles or runs 8-bit PWM.
// - Only module 4 can act as watchdog.
// - Every module has its own mode register.
// - Mode bit 0 gates the module flag onto the request.
// - Mode bit 1 selects PWM.
// - Mode bit 2 toggles the pin on each match.
// - Mode bit 3 sets the module flag on each match.
// - Mode bits 4 and 5 enable falling and rising capture.
// - Mode bit 6 enables the comparator; cleared means no matches.
// - A capture copies both counter bytes into the module pair.
// - PWM pin low while counter low byte below compare low byte.
// - PWM compare low reloads from compare high on low byte rollover.
// - Module 4 watchdog match also raises a one-cycle internal reset pulse; its flag and toggle still act.
`timescale 1ns/1ps
module counter_array_capture_compare (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [7:0]  p1_in,
    input  wire logic [7:0]  p1_latch,
    output logic [7:0]       p1_out,
    output logic [7:0]       p1_oe_n,
    input  wire logic        timer0_overflow,
    output logic             machine_cycle,
    output logic             irq_request,
    output logic             internal_reset
);
    localparam int N = pca_pkg::NUM_MODULES;

    logic                  wr_go, wr_hit, we, counter_we, read_hit;
    logic                  double_speed_select, overflow_flag, run;
    logic                  count_tick, src_tick, fast_tick;
    logic [7:0]            wr_idx, rd_idx, read_byte, array_mode_register;
    logic [7:0]            p1_meta, p1_sync, p1_prev, rise, fall;
    logic [N-1:0]          module_event_flag, irq_enables, low_we, high_we;
    logic [N-1:0]          match, event_pulse, level, owned;
    pca_pkg::module_mode_t module_mode_register [N];
    logic [15:0]           counter, count_next;
    logic [3:0]            mc_cnt, fast_cnt;
    logic [7:0]            cmp_low  [N];
    logic [7:0]            cmp_high [N];
    pca_pkg::count_source_t source;

    function automatic logic mapped(input logic [7:0] idx);
        return idx == pca_pkg::IDX_CLOCK_SPEED || idx == pca_pkg::IDX_ARRAY_CTRL
            || idx == pca_pkg::IDX_ARRAY_MODE || idx == pca_pkg::IDX_COUNTER_LOW
            || idx == pca_pkg::IDX_COUNTER_HIGH
            || pca_pkg::in_group(idx, pca_pkg::IDX_MODULE_MODE)
            || pca_pkg::in_group(idx, pca_pkg::IDX_COMPARE_LOW)
            || pca_pkg::in_group(idx, pca_pkg::IDX_COMPARE_HIGH);
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    assign wr_go   = awvalid && wvalid && !bvalid;
    assign awready = wr_go;
    assign wready  = wr_go;
    assign arready = !rvalid;
    assign wr_idx  = awaddr[9:2];
    assign rd_idx  = araddr[9:2];
    assign wr_hit  = awaddr[11:10] == 2'b00 && awaddr[1:0] == 2'b00 && mapped(wr_idx);
    // Only the low lane carries register data; other lanes are ignored
    assign we      = wr_go && wr_hit && wstrb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= pca_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? pca_pkg::RESP_OKAY : pca_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_comb begin
        read_hit  = araddr[11:10] == 2'b00 && araddr[1:0] == 2'b00 && mapped(rd_idx);
        read_byte = 8'h00;
        if (rd_idx == pca_pkg::IDX_CLOCK_SPEED) begin
            read_byte = {7'h00, double_speed_select};
        end else if (rd_idx == pca_pkg::IDX_ARRAY_CTRL) begin
            read_byte = {overflow_flag, run, 1'b0, module_event_flag};
        end else if (rd_idx == pca_pkg::IDX_ARRAY_MODE) begin
            read_byte = array_mode_register;
        end else if (rd_idx == pca_pkg::IDX_COUNTER_LOW) begin
            read_byte = counter[7:0];
        end else if (rd_idx == pca_pkg::IDX_COUNTER_HIGH) begin
            read_byte = counter[15:8];
        end
        for (int i = 0; i < N; i++) begin
            if (rd_idx == pca_pkg::IDX_MODULE_MODE + 8'(i)) begin
                read_byte = {1'b0, module_mode_register[i][6:0]};
            end
            if (rd_idx == pca_pkg::IDX_COMPARE_LOW + 8'(i)) begin
                read_byte = cmp_low[i];
            end
            if (rd_idx == pca_pkg::IDX_COMPARE_HIGH + 8'(i)) begin
                read_byte = cmp_high[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= pca_pkg::RESP_OKAY;
        end else if (arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, read_byte};
            rresp  <= read_hit ? pca_pkg::RESP_OKAY : pca_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            double_speed_select <= 1'b0;
        end else if (we && wr_idx == pca_pkg::IDX_CLOCK_SPEED) begin
            // Upper bits are not stored; software keeps them zero
            double_speed_select <= wdata[pca_pkg::SPEED_X2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            array_mode_register <= pca_pkg::RESET_BYTE;
        end else if (we && wr_idx == pca_pkg::IDX_ARRAY_MODE) begin
            array_mode_register <= wdata[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < N; i++) begin
            if (!aresetn) begin
                module_mode_register[i] <= pca_pkg::module_mode_t'(pca_pkg::RESET_BYTE);
            end else if (we && wr_idx == pca_pkg::IDX_MODULE_MODE + 8'(i)) begin
                module_mode_register[i] <= pca_pkg::module_mode_t'(wdata[7:0]);
            end
        end
    end

    // Hardware set wins over a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag     <= 1'b0;
            run               <= 1'b0;
            module_event_flag <= '0;
        end else begin
            if (we && wr_idx == pca_pkg::IDX_ARRAY_CTRL) begin
                run               <= wdata[pca_pkg::CTRL_RUN];
                overflow_flag     <= wdata[pca_pkg::CTRL_OVERFLOW]
                                     || (count_tick && counter == 16'hffff);
                module_event_flag <= wdata[N-1:0] | event_pulse;
            end else begin
                overflow_flag     <= overflow_flag || (count_tick && counter == 16'hffff);
                module_event_flag <= module_event_flag | event_pulse;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and time base
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1_meta <= 8'hff;
            p1_sync <= 8'hff;
            p1_prev <= 8'hff;
        end else begin
            p1_meta <= p1_in;
            p1_sync <= p1_meta;
            p1_prev <= p1_sync;
        end
    end
    assign rise = p1_sync & ~p1_prev;
    assign fall = ~p1_sync & p1_prev;

    assign machine_cycle = mc_cnt >= pca_pkg::period(double_speed_select, 1'b0) - 4'd1;
    assign fast_tick     = fast_cnt >= pca_pkg::period(double_speed_select, 1'b1) - 4'd1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mc_cnt   <= 4'h0;
            fast_cnt <= 4'h0;
        end else begin
            mc_cnt   <= machine_cycle ? 4'h0 : mc_cnt + 4'd1;
            fast_cnt <= fast_tick ? 4'h0 : fast_cnt + 4'd1;
        end
    end

    assign source = pca_pkg::count_source_t'(
        array_mode_register[pca_pkg::MODE_SRC_HI:pca_pkg::MODE_SRC_LO]);

    always_comb begin
        unique case (source)
            pca_pkg::SRC_MACHINE: src_tick = machine_cycle;
            pca_pkg::SRC_FAST:    src_tick = fast_tick;
            pca_pkg::SRC_TIMER0:  src_tick = timer0_overflow;
            pca_pkg::SRC_EXT:     src_tick = fall[pca_pkg::EXT_PIN];
        endcase
    end

    assign counter_we = we && (wr_idx == pca_pkg::IDX_COUNTER_LOW
                               || wr_idx == pca_pkg::IDX_COUNTER_HIGH);
    assign count_tick = run && src_tick && !counter_we;
    assign count_next = counter + 16'd1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= 16'h0000;
        end else if (we && wr_idx == pca_pkg::IDX_COUNTER_LOW) begin
            counter[7:0] <= wdata[7:0];
        end else if (we && wr_idx == pca_pkg::IDX_COUNTER_HIGH) begin
            counter[15:8] <= wdata[7:0];
        end else if (count_tick) begin
            counter <= count_next;
        end
    end

    // ----------------------------------------------------------------
    // Modules and outputs
    // ----------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : gen_mod
        assign low_we[g]      = we && wr_idx == pca_pkg::IDX_COMPARE_LOW + 8'(g);
        assign high_we[g]     = we && wr_idx == pca_pkg::IDX_COMPARE_HIGH + 8'(g);
        assign irq_enables[g] = module_mode_register[g].module_irq_enable;
        compare_module u_mod (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .mode         (module_mode_register[g]),
            .count_now    (counter),
            .count_next   (count_next),
            .count_tick   (count_tick),
            .low_we       (low_we[g]),
            .high_we      (high_we[g]),
            .wdata        (wdata[7:0]),
            .pin_rise     (rise[pca_pkg::FIRST_MOD_PIN + g]),
            .pin_fall     (fall[pca_pkg::FIRST_MOD_PIN + g]),
            .compare_low  (cmp_low[g]),
            .compare_high (cmp_high[g]),
            .match        (match[g]),
            .event_pulse  (event_pulse[g]),
            .pin_level    (level[g]),
            .pin_owned    (owned[g])
        );
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request    <= 1'b0;
            internal_reset <= 1'b0;
            p1_out         <= 8'hff;
            p1_oe_n        <= 8'hff;
        end else begin
            irq_request    <= (overflow_flag && array_mode_register[pca_pkg::MODE_OVF_IE])
                              || |(module_event_flag & irq_enables);
            internal_reset <= match[N-1] && array_mode_register[pca_pkg::MODE_WDOG];
            // Unused bits stay ordinary quasi-bidirectional port I/O
            p1_out  <= p1_latch;
            p1_oe_n <= p1_latch;
            for (int i = 0; i < N; i++) begin
                if (owned[i]) begin
                    p1_out[pca_pkg::FIRST_MOD_PIN + i]  <= level[i];
                    p1_oe_n[pca_pkg::FIRST_MOD_PIN + i] <= level[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence x2_cycle_start;
        machine_cycle && double_speed_select ##1 (double_speed_select && !machine_cycle)[*5];
    endsequence

    chk_mc_double: assert property (x2_cycle_start ##1 double_speed_select |-> machine_cycle)
        else $error("double speed machine cycle not 6 clocks");
    chk_mc_spacing: assert property (machine_cycle |=> !machine_cycle[*5])
        else $error("machine cycle shorter than 6 clocks");
    chk_count_wrap: assert property (
        count_tick && counter == 16'hffff |=> counter == 16'h0000 && overflow_flag)
        else $error("counter wrap or overflow wrong");
    chk_count_step: assert property (
        count_tick |=> counter == $past(counter) + 16'd1)
        else $error("counter did not step by one");
    chk_flag_set: assert property (
        event_pulse[0] |=> module_event_flag[0])
        else $error("module flag not set");
    chk_wdog_reset: assert property (
        match[N-1] && array_mode_register[pca_pkg::MODE_WDOG] |=> internal_reset)
        else $error("watchdog match gave no reset");
    chk_irq_gate: assert property (
        module_event_flag == '0 && !overflow_flag |=> !irq_request)
        else $error("request without a flag");
    chk_edge_once: assert property (
        rise[pca_pkg::EXT_PIN] |=> !rise[pca_pkg::EXT_PIN])
        else $error("edge seen twice");
endmodule

// ===== tb/port1_far_side.sv
// Purpose: Far side of port 1, pins with pull-ups
// Assumes: Bench holds each pin level two cycles or more
// Notes:   Device only pulls low, a released pin shows the pull-up
`timescale 1ns/1ps
module port1_far_side (
    input  wire logic [7:0] pin_drv,
    input  wire logic [7:0] p1_oe_n,
    output logic [7:0]      p1_in
);
    assign p1_in = pin_drv & p1_oe_n;
endmodule

// ===== tb/test_counter_array_capture_compare.sv
// Purpose: Register bus tests of the counter array
// Assumes: Timer 0 pulses or the fast clock drive the counter
// Notes:   Counter is preset so captures and matches are exact
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); end end
module test_counter_array_capture_compare;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, t0;
    logic        awready, wready, bvalid, arready, rvalid, mc, irq, irst;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [7:0]  pin_drv, p1_in, p1_out, p1_oe_n, latch;
    logic [1:0]  bresp, rresp, r;
    int          bad_count = 0, n_compared = 0, n, n_rst = 0;
    counter_array_capture_compare uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .p1_in, .p1_latch(latch), .p1_out,
        .p1_oe_n, .timer0_overflow(t0), .machine_cycle(mc), .irq_request(irq),
        .internal_reset(irst));
    port1_far_side far (.pin_drv, .p1_oe_n, .p1_in);
    // Internal reset is a one-cycle pulse, so count it where it stands
    always @(posedge aclk) begin
        if (irst === 1'b1) n_rst++;
    end
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        r = rresp;
        `CHK(rdata, 32'(e))
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic tick;
        t0 <= 1'b1;
        @(posedge aclk);
        t0 <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    task automatic per(output int c);
        c = 0;
        @(posedge aclk iff mc === 1'b1);
        do begin @(posedge aclk); c++; end while (mc !== 1'b1);
    endtask
    task automatic duty(output int c);
        c = 0;
        repeat (512) begin
            @(posedge aclk);
            if (p1_out[6] === 1'b1) c++;
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, t0} = '0;
        {awaddr, araddr, wdata} = '0;
        pin_drv = 8'hff;
        latch = 8'hff;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(pca_pkg::IDX_CLOCK_SPEED, 8'h00);
        per(n); `CHK(n, 12)
        wr(pca_pkg::IDX_CLOCK_SPEED, 8'h01);
        rd(pca_pkg::IDX_CLOCK_SPEED, 8'h01);
        per(n); `CHK(n, 6)
        rd(8'h00, 8'h00); `CHK(r, pca_pkg::RESP_SLVERR)
        wr(8'h00, 8'h55); `CHK(r, pca_pkg::RESP_SLVERR)
        $display("test clock done");
        wr(pca_pkg::IDX_ARRAY_MODE, 8'h04);
        wr(pca_pkg::IDX_COUNTER_HIGH, 8'h12);
        wr(pca_pkg::IDX_COUNTER_LOW, 8'h34);
        wr(pca_pkg::IDX_MODULE_MODE, 8'h21);
        wr(pca_pkg::IDX_ARRAY_CTRL, 8'h40);
        pin_drv[3] <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(pca_pkg::IDX_ARRAY_CTRL, 8'h40);
        pin_drv[3] <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(pca_pkg::IDX_COMPARE_LOW, 8'h34);
        rd(pca_pkg::IDX_COMPARE_HIGH, 8'h12);
        rd(pca_pkg::IDX_ARRAY_CTRL, 8'h41); `CHK(irq, 1'b1)
        wr(pca_pkg::IDX_ARRAY_CTRL, 8'h40);
        $display("test capture done");
        // Module 2 shares the match value but has its comparator off
        wr(pca_pkg::IDX_MODULE_MODE + 8'h01, 8'h4c);
        wr(pca_pkg::IDX_MODULE_MODE + 8'h02, 8'h08);
        wr(pca_pkg::IDX_COMPARE_LOW + 8'h01, 8'h35);
        wr(pca_pkg::IDX_COMPARE_HIGH + 8'h01, 8'h12);
        wr(pca_pkg::IDX_COMPARE_LOW + 8'h02, 8'h35);
        wr(pca_pkg::IDX_COMPARE_HIGH + 8'h02, 8'h12);
        tick;
        `CHK(p1_out[4], 1'b0)
        `CHK(irq, 1'b0)
        `CHK(p1_oe_n[4], 1'b0)
        rd(pca_pkg::IDX_ARRAY_CTRL, 8'h42);
        rd(pca_pkg::IDX_COUNTER_LOW, 8'h35);
        // Bits 0 and 1 follow the latch, bit 4 stays with module 1
        latch <= 8'hfc;
        repeat (2) @(posedge aclk);
        `CHK(p1_out, 8'hec)
        wr(pca_pkg::IDX_COUNTER_HIGH, 8'hff);
        wr(pca_pkg::IDX_COUNTER_LOW, 8'hff);
        tick;
        rd(pca_pkg::IDX_ARRAY_CTRL, 8'hc2);
        rd(pca_pkg::IDX_COUNTER_HIGH, 8'h00);
        $display("test counter done");
        // Module 3 matches first and must not reset; module 4 then does
        wr(pca_pkg::IDX_ARRAY_MODE, 8'h44);
        wr(pca_pkg::IDX_MODULE_MODE + 8'h03, 8'h40);
        wr(pca_pkg::IDX_MODULE_MODE + 8'h04, 8'h40);
        wr(pca_pkg::IDX_COMPARE_LOW + 8'h03, 8'h01);
        wr(pca_pkg::IDX_COMPARE_LOW + 8'h04, 8'h02);
        tick;
        `CHK(n_rst, 0)
        tick;
        `CHK(n_rst, 1)
        $display("test watchdog done");
        // Fast source at double speed: one count per 2 clocks, 512 clocks a period
        wr(pca_pkg::IDX_ARRAY_MODE, 8'h02);
        wr(pca_pkg::IDX_COMPARE_HIGH + 8'h03, 8'h80);
        wr(pca_pkg::IDX_COMPARE_LOW + 8'h03, 8'h80);
        wr(pca_pkg::IDX_MODULE_MODE + 8'h03, 8'h42);
        repeat (8) @(posedge aclk);
        duty(n); `CHK(n, 256)
        wr(pca_pkg::IDX_COMPARE_HIGH + 8'h03, 8'h40);
        repeat (520) @(posedge aclk);
        duty(n); `CHK(n, 384)
        $display("test pwm done");
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        wrap_up;
    end
endmodule
